/* inc/stk_pkg.sv */
// Purpose: constants and types for the system tick timer block
// Assumes: avalon-mm slave with 32-bit data, word addressing by byte offset
// Notes: shared by the top module and its counter core
//
// Overview of operation
// - calibration bit 31 always reads one: no separate reference clock
// - calibration bit 30 always reads one: ten ms count is inexact
// - calibration bits 23:0 always read zero: no calibration value
// - counter advances only on the controller clock, holds when gated
// - enabled counter decrements to zero, reloads next clock, continues
// - write to current value clears it and the reached-zero flag
// - reached-zero flag bit 16 sets at zero, clears on control read
// - bit 0 enables counting; bit 1 lets zero raise the tick request
package stk_pkg;
    localparam int CNT_W = 24;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_CURRENT = 8'h08;
    localparam logic [7:0] OFS_CALIB = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_TICK_IRQ_ENABLE = 1;
    localparam int BIT_CLKSRC = 2;
    localparam int BIT_FLAG = 16;
    localparam int BIT_NO_REF_CLOCK_FLAG = 31;
    localparam int BIT_INEXACT = 30;
    localparam logic [31:0] CALIB_VALUE = 32'hc000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam int IRQ_N = 2;
    localparam int IRQ_ZERO = 0;
    localparam int IRQ_CLEAR = 1;

    typedef struct packed {
        logic enable;
        logic tick_irq_enable;
    } stk_ctrl_t;

    typedef struct packed {
        logic clear_cur;
        logic [CNT_W-1:0] reload;
    } stk_cfg_t;
endpackage : stk_pkg

/* verilog/stk_counter.sv */
// Purpose: tick down-counter core
// Assumes: runs on the controller clock; gating that clock freezes it
// Notes: reload is loaded in the clock after zero is reached
`timescale 1ns/1ns
`default_nettype none
module stk_counter
    import stk_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire stk_ctrl_t ctrl,
    input wire stk_cfg_t cfg,
    output logic [CNT_W-1:0] count_q,
    output logic zero_pulse
);
    logic [CNT_W-1:0] count_d;

    // only decrements from one count as reaching zero, not reload 0
    always_comb begin
        count_d = count_q;
        zero_pulse = 1'b0;
        if (cfg.clear_cur) begin
            count_d = CNT_ZERO;
        end else if (ctrl.enable) begin
            if (count_q == CNT_ZERO) begin
                count_d = cfg.reload;
            end else begin
                count_d = count_q - CNT_ONE;
                zero_pulse = (count_q == CNT_ONE);
            end
        end
    end

    // sole clock is the controller clock, so a stopped clock holds it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    chk_reload_after_zero: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl.enable && !cfg.clear_cur && count_q == CNT_ZERO
        |=> count_q == $past(cfg.reload))
        else $error("reload not taken after zero");
    chk_count_holds: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl.enable && !cfg.clear_cur |=> $stable(count_q))
        else $error("counter moved while disabled");
endmodule : stk_counter
`default_nettype wire

/* verilog/stk_timer.sv */
// Purpose: system tick timer with registers on avalon-mm
// Assumes: word accesses only; writes with byteenable other than all ones are ignored
// Notes: zero-wait writes, reads answer one cycle later
`timescale 1ns/1ns
`default_nettype none
module stk_timer
    import stk_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic tick_req,
    output logic irq
);
    logic rst_meta_q, rst_n;
    stk_ctrl_t ctrl_q;
    stk_cfg_t cfg;
    logic [CNT_W-1:0] reload_q, count;
    logic flag_q, zero_pulse, rd_done_q, word_ok;
    logic wr_ctrl, wr_reload, wr_current, rd_ctrl, wr_stat, wr_mask;
    logic [IRQ_N-1:0] stat_q, mask_q, events;
    logic [31:0] rdata_d;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // partial-word writes dropped: timer fields must change whole
    assign word_ok = (avs_byteenable == 4'hf);
    assign wr_ctrl = avs_write && word_ok && avs_address == OFS_CTRL;
    assign wr_reload = avs_write && word_ok && avs_address == OFS_RELOAD;
    assign wr_current = avs_write && word_ok && avs_address == OFS_CURRENT;
    assign wr_stat = avs_write && word_ok && avs_address == OFS_IRQ_STAT;
    assign wr_mask = avs_write && word_ok && avs_address == OFS_IRQ_MASK;
    assign rd_ctrl = avs_read && !rd_done_q && avs_address == OFS_CTRL;
    assign avs_waitrequest = avs_read && !rd_done_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= avs_read && !rd_done_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            ctrl_q.enable <= avs_writedata[BIT_ENABLE];
            ctrl_q.tick_irq_enable <= avs_writedata[BIT_TICK_IRQ_ENABLE];
        end
    end

    // reset value is zero; software loads it first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= CNT_ZERO;
        end else if (wr_reload) begin
            reload_q <= avs_writedata[CNT_W-1:0];
        end
    end

    assign cfg.clear_cur = wr_current;
    assign cfg.reload = reload_q;

    stk_counter #() u_counter (
        .clk(sys_clk),
        .rst_n(rst_n),
        .ctrl(ctrl_q),
        .cfg(cfg),
        .count_q(count),
        .zero_pulse(zero_pulse)
    );

    // set wins over a read in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (zero_pulse) begin
            flag_q <= 1'b1;
        end else if (rd_ctrl || wr_current) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_req <= 1'b0;
        end else begin
            tick_req <= zero_pulse && ctrl_q.tick_irq_enable;
        end
    end

    assign events[IRQ_ZERO] = zero_pulse;
    assign events[IRQ_CLEAR] = wr_current;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= events | (stat_q & ~(wr_stat ?
                avs_writedata[IRQ_N-1:0] : '0));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= '0;
        end else if (wr_mask) begin
            mask_q <= avs_writedata[IRQ_N-1:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    always_comb begin
        rdata_d = UNMAPPED_READ;
        unique case (avs_address)
            OFS_CTRL: begin
                rdata_d[BIT_ENABLE] = ctrl_q.enable;
                rdata_d[BIT_TICK_IRQ_ENABLE] = ctrl_q.tick_irq_enable;
                rdata_d[BIT_CLKSRC] = 1'b1;
                rdata_d[BIT_FLAG] = flag_q;
            end
            OFS_RELOAD: rdata_d[CNT_W-1:0] = reload_q;
            OFS_CURRENT: rdata_d[CNT_W-1:0] = count;
            // fixed value; no write path reaches it
            OFS_CALIB: rdata_d = CALIB_VALUE;
            OFS_IRQ_STAT: rdata_d[IRQ_N-1:0] = stat_q;
            OFS_IRQ_MASK: rdata_d[IRQ_N-1:0] = mask_q;
            default: rdata_d = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !rd_done_q) begin
            avs_readdata <= rdata_d;
        end
    end

    chk_calib_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        avs_read && rd_done_q && avs_address == OFS_CALIB
        |-> avs_readdata == CALIB_VALUE)
        else $error("calibration value wrong");
    chk_flag_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        zero_pulse |=> flag_q)
        else $error("flag not set at zero");
    chk_flag_read_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_ctrl && !zero_pulse |=> !flag_q)
        else $error("flag not cleared by read");
    chk_current_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_current |=> count == CNT_ZERO && !flag_q && !tick_req)
        else $error("current write did not clear");
    chk_tick_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick_req |-> $past(zero_pulse) && $past(ctrl_q.tick_irq_enable))
        else $error("tick request without cause");
    chk_read_latency: assert property (@(posedge sys_clk) disable iff (!rst_n)
        avs_read && !rd_done_q |=> !avs_waitrequest || !avs_read)
        else $error("read answer late");

    cov_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
        zero_pulse ##1 count == reload_q);
    cov_tick: cover property (@(posedge sys_clk) disable iff (!rst_n)
        tick_req);
    cov_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) irq);
endmodule : stk_timer
`default_nettype wire

/* sim/tb.sv */
// Purpose: self-checking bench for the system tick timer
// Assumes: reads answer after one wait cycle, writes never wait
// Notes: clock can be stopped to model the low-power clock gate
`timescale 1ns/1ns
`default_nettype none
module tb;
    import stk_pkg::*;
    logic sys_clk, rstn, clk_run, avs_read, avs_write;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, a, b, d0;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, tick_req, irq, wait_s, tick_s;
    logic [31:0] data_s;
    int failures, checks, n;

    stk_timer stk_timer_inst (.sys_clk(sys_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tick_req(tick_req), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever begin
            #25;
            if (clk_run) sys_clk = ~sys_clk;
        end
    end

    // pre-edge copies, so sampling never races the design's own updates
    always @(posedge sys_clk) begin
        wait_s <= avs_waitrequest;
        tick_s <= tick_req;
        data_s <= avs_readdata;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task bus(input logic wr, input logic [7:0] ad, input logic [31:0] d,
             input logic [3:0] be, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge sys_clk);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (wait_s !== 1'b0 && k < 20);
        if (k >= 20) failures++;
        r = data_s;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, 4'hf, q);
    endtask : wr

    task rd(input logic [7:0] ad, output logic [31:0] r);
        bus(1'b0, ad, 32'h0000_0000, 4'hf, r);
    endtask : rd

    task wait_tick();
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (tick_s !== 1'b1 && n < 50);
    endtask : wait_tick

    task t_calib();
        rd(OFS_CALIB, q);
        chk(q, 32'hc000_0000);
        wr(OFS_CALIB, 32'hffff_ffff);
        rd(OFS_CALIB, q);
        chk(q, 32'hc000_0000);
        rd(8'h20, q);
        chk(q, 32'h0000_0000);
        $display("calibration test done");
    endtask : t_calib

    task t_tick();
        // period of 4 clocks wanted, so reload is 4 - 1
        wr(OFS_RELOAD, 32'h0000_0003);
        wr(OFS_CURRENT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0003);
        wait_tick();
        wait_tick();
        chk(32'(n), 32'h4);
        wr(OFS_CTRL, 32'h0000_0001);
        wait_tick();
        chk(32'(n), 32'd50);
        wr(OFS_CTRL, 32'h0000_0000);
        rd(OFS_CTRL, q);
        chk(q, 32'h0001_0004);
        rd(OFS_CTRL, q);
        chk(q, 32'h0000_0004);
        bus(1'b1, OFS_RELOAD, 32'h0000_0005, 4'h3, q);
        rd(OFS_RELOAD, q);
        chk(q, 32'h0000_0003);
        rd(OFS_IRQ_STAT, q);
        chk(q, 32'h0000_0003);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'h0000_0003);
        chk(irq, 1'b0);
        rd(OFS_IRQ_STAT, q);
        chk(q, 32'h0000_0000);
        $display("tick test done");
    endtask : t_tick

    task t_clear();
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (12) @(posedge sys_clk);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CURRENT, 32'h0000_0abc);
        rd(OFS_CTRL, q);
        chk(q, 32'h0000_0004);
        rd(OFS_CURRENT, q);
        chk(q, 32'h0000_0000);
        $display("clear test done");
    endtask : t_clear

    task t_gate();
        wr(OFS_RELOAD, 32'h0000_1000);
        wr(OFS_CURRENT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_CURRENT, a);
        rd(OFS_CURRENT, b);
        d0 = a - b;
        chk(d0, 32'h3);
        rd(OFS_CURRENT, a);
        // even number of half periods keeps the clock phase
        clk_run = 1'b0;
        #1000;
        clk_run = 1'b1;
        rd(OFS_CURRENT, b);
        chk(a - b, d0);
        $display("clock gate test done");
    endtask : t_gate

    task test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial begin
        #100000;
        failures++;
        test_done();
    end

    initial begin
        failures = 0;
        checks = 0;
        clk_run = 1'b1;
        rstn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_calib();
        t_tick();
        t_clear();
        t_gate();
        test_done();
    end
endmodule : tb
`default_nettype wire
